/* include/pif_defs.svh */
`ifndef PIF_DEFS_SVH
`define PIF_DEFS_SVH

// ----------------------------------------------------------------------
// register map, byte addresses on the apb
// ----------------------------------------------------------------------
`define PIF_ADDR_W 12
`define PIF_FLAG_BASE 12'h000
`define PIF_ENABLE_BASE 12'h040
`define PIF_CONTROL_ADDR 12'h080
`define PIF_IRQ_STATUS_ADDR 12'h084
`define PIF_IRQ_MASK_ADDR 12'h088
`define PIF_GROUP_COUNT 9

// ----------------------------------------------------------------------
// implemented bits of each flag group, same layout for enables
// ----------------------------------------------------------------------
`define PIF_MASK_G0 8'h31
`define PIF_MASK_G1 8'hC3
`define PIF_MASK_G2 8'h43
`define PIF_MASK_G3 8'h3F
`define PIF_MASK_G4 8'h3F
`define PIF_MASK_G5 8'hF7
`define PIF_MASK_G6 8'h1F
`define PIF_MASK_G7 8'hF7
`define PIF_MASK_G8 8'h3F
`define PIF_FLAG_RESET 8'h00
`define PIF_ENABLE_RESET 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PIF_CAPTURE_UNIT1_FLAG_BIT 0
`define PIF_SCANNER_DONE_FLAG_BIT 7
`define PIF_CHECKSUM_DONE_FLAG_BIT 6
`define PIF_NONVOLATILE_DONE_FLAG_BIT 5
`define PIF_NUMERIC_OSC_ROLLOVER_FLAG_BIT 4
`define PIF_WAVEFORM_GEN1_SHUTDOWN_FLAG_BIT 0
`define PIF_MEASURE_TIMER1_OVERFLOW_FLAG_BIT 0
`define PIF_MEASURE_TIMER1_PERIOD_FLAG_BIT 1
`define PIF_MEASURE_TIMER1_WIDTH_FLAG_BIT 2
`define PIF_MEASURE_TIMER2_OVERFLOW_FLAG_BIT 3
`define PIF_MEASURE_TIMER2_PERIOD_FLAG_BIT 4
`define PIF_MEASURE_TIMER2_WIDTH_FLAG_BIT 5
`define PIF_GLOBAL_INT_ENABLE_BIT 7
`define PIF_PERIPHERAL_INT_ENABLE_BIT 6
`define PIF_INT_EDGE_SELECT_BIT 0
`define PIF_CONTROL_MASK 8'hC1
`define PIF_CONTROL_RESET 8'h00

// ----------------------------------------------------------------------
// block interrupt status and mask, write one to clear status
// ----------------------------------------------------------------------
`define PIF_IRQ_REQ_RISE_BIT 0
`define PIF_IRQ_BUS_ERROR_BIT 1
`define PIF_IRQ_MASK_BITS 8'h03
`define PIF_IRQ_RESET 8'h00

`endif

/* include/pif_pkg.sv */
package pif_pkg;

	// operating mode of one capture/compare/pwm unit
	typedef enum logic [1:0] {
		PIF_MODE_OFF = 2'b00,
		PIF_MODE_CAPTURE = 2'b01,
		PIF_MODE_COMPARE = 2'b11,
		PIF_MODE_PWM = 2'b10
	} pif_ccp_mode_e;

	typedef logic [7:0] pif_byte_t;

endpackage

/* src/pif_flag_group.sv */
`timescale 1ns/1ps
`include "pif_defs.svh"

module pif_flag_group #(
	parameter logic [7:0] IMPL_MASK = 8'hFF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// software write
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// hardware set pulses
	input wire logic [7:0] hw_set,
	// stored flags
	output logic [7:0] value
);

	logic [7:0] next_value;

	// hardware set is or-ed in after the write so an event never drops
	always_comb begin
		next_value = ((wr_en ? wr_data : value) | hw_set) & IMPL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= `PIF_FLAG_RESET;
		end else begin
			value <= next_value;
		end
	end

endmodule

/* src/pif_intr_flags.sv */
`timescale 1ns/1ps
`include "pif_defs.svh"

module pif_intr_flags (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event groups zero to five, one-cycle pulses
	input wire logic [7:0] event_group0,
	input wire logic [7:0] event_group1,
	input wire logic [7:0] event_group2,
	input wire logic [7:0] event_group3,
	input wire logic [7:0] event_group4,
	input wire logic [7:0] event_group5,
	// capture/compare/pwm units, bit n is unit n+1
	input wire pif_pkg::pif_ccp_mode_e ccp1_mode,
	input wire pif_pkg::pif_ccp_mode_e ccp2_mode,
	input wire pif_pkg::pif_ccp_mode_e ccp3_mode,
	input wire pif_pkg::pif_ccp_mode_e ccp4_mode,
	input wire pif_pkg::pif_ccp_mode_e ccp5_mode,
	input wire logic [4:0] ccp_capture_event,
	input wire logic [4:0] ccp_compare_match,
	input wire logic [4:0] ccp_pwm_trailing_edge,
	// completion sources
	input wire logic scanner_run_bit,
	input wire logic checksum_busy,
	input wire logic nonvolatile_op_done,
	input wire logic numeric_osc_rollover,
	input wire logic [2:0] waveform_gen_shutdown,
	// signal measurement timers, bit n is timer n+1
	input wire logic [1:0] measure_timer_overflow,
	input wire logic [1:0] measure_timer_period_acq,
	input wire logic [1:0] measure_timer_width_acq,
	// requests
	output logic cpu_int_request,
	output logic int_edge_select,
	output logic irq
);

	import pif_pkg::*;

	// ----------------------------------------------------------------------
	// constants and decode helpers
	// ----------------------------------------------------------------------
	localparam int GROUPS = `PIF_GROUP_COUNT;
	localparam pif_byte_t FLAG_MASK [0:8] = '{
		`PIF_MASK_G0, `PIF_MASK_G1, `PIF_MASK_G2,
		`PIF_MASK_G3, `PIF_MASK_G4, `PIF_MASK_G5,
		`PIF_MASK_G6, `PIF_MASK_G7, `PIF_MASK_G8
	};

	// returns {hit, index} for a bank of GROUPS words starting at base
	function automatic logic [4:0] bank_decode(input logic [11:0] addr, input logic [11:0] base);
		logic [11:0] off;
		off = addr - base;
		bank_decode = 5'h00;
		if (addr >= base && off[1:0] == 2'b00 && off[11:2] < 10'(GROUPS)) begin
			bank_decode = {1'b1, off[5:2]};
		end
	endfunction

	// unmapped or misaligned words answer with an error
	function automatic logic addr_mapped(input logic [11:0] addr);
		logic [4:0] f;
		logic [4:0] e;
		f = bank_decode(addr, `PIF_FLAG_BASE);
		e = bank_decode(addr, `PIF_ENABLE_BASE);
		addr_mapped = f[4] || e[4] || addr == `PIF_CONTROL_ADDR
			|| addr == `PIF_IRQ_STATUS_ADDR || addr == `PIF_IRQ_MASK_ADDR;
	endfunction

	// ----------------------------------------------------------------------
	// apb handshake
	// ----------------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic [4:0] flag_dec;
	logic [4:0] enable_dec;
	logic mapped;

	// zero wait states keep software access latency fixed
	assign pready = 1'b1;
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign flag_dec = bank_decode(paddr, `PIF_FLAG_BASE);
	assign enable_dec = bank_decode(paddr, `PIF_ENABLE_BASE);
	assign mapped = addr_mapped(paddr);
	assign wr_access = access_phase && pwrite && mapped;
	// an error answer still ends in one cycle; the write is dropped
	assign pslverr = access_phase && !mapped;

	// ----------------------------------------------------------------------
	// hardware event sources
	// ----------------------------------------------------------------------
	pif_byte_t flag_set [0:8];
	pif_byte_t flag_q [0:8];
	pif_byte_t enable_q [0:8];
	pif_ccp_mode_e ccp_mode [0:4];
	logic [4:0] ccp_set;
	logic scanner_run_prev;
	logic checksum_busy_prev;
	logic [2:0] shutdown_prev;

	assign ccp_mode[0] = ccp1_mode;
	assign ccp_mode[1] = ccp2_mode;
	assign ccp_mode[2] = ccp3_mode;
	assign ccp_mode[3] = ccp4_mode;
	assign ccp_mode[4] = ccp5_mode;

	// the unit's mode picks which of its three events may set the flag
	genvar u;
	generate
		for (u = 0; u < 5; u++) begin : g_ccp
			always_comb begin
				case (ccp_mode[u])
					PIF_MODE_CAPTURE: ccp_set[u] = ccp_capture_event[u];
					PIF_MODE_COMPARE: ccp_set[u] = ccp_compare_match[u];
					PIF_MODE_PWM: ccp_set[u] = ccp_pwm_trailing_edge[u];
					default: ccp_set[u] = 1'b0;
				endcase
			end
		end
	endgenerate

	// previous levels for the falling and rising edge detectors
	// they reset to the idle low level, so a release makes no false falling edge; a shutdown already high at release sets its flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scanner_run_prev <= 1'b0;
			checksum_busy_prev <= 1'b0;
			shutdown_prev <= 3'b000;
		end else begin
			scanner_run_prev <= scanner_run_bit;
			checksum_busy_prev <= checksum_busy;
			shutdown_prev <= waveform_gen_shutdown;
		end
	end

	// sources set flags whatever the enables, so software can poll
	always_comb begin
		flag_set[0] = event_group0;
		flag_set[1] = event_group1;
		flag_set[2] = event_group2;
		flag_set[3] = event_group3;
		flag_set[4] = event_group4;
		flag_set[5] = event_group5;
		flag_set[6] = 8'h00;
		flag_set[6][`PIF_CAPTURE_UNIT1_FLAG_BIT +: 5] = ccp_set;
		flag_set[7] = 8'h00;
		flag_set[7][`PIF_SCANNER_DONE_FLAG_BIT] =
			scanner_run_prev && !scanner_run_bit;
		flag_set[7][`PIF_CHECKSUM_DONE_FLAG_BIT] =
			checksum_busy_prev && !checksum_busy;
		flag_set[7][`PIF_NONVOLATILE_DONE_FLAG_BIT] = nonvolatile_op_done;
		flag_set[7][`PIF_NUMERIC_OSC_ROLLOVER_FLAG_BIT] = numeric_osc_rollover;
		flag_set[7][`PIF_WAVEFORM_GEN1_SHUTDOWN_FLAG_BIT +: 3] =
			waveform_gen_shutdown & ~shutdown_prev;
		flag_set[8] = 8'h00;
		flag_set[8][`PIF_MEASURE_TIMER1_OVERFLOW_FLAG_BIT] = measure_timer_overflow[0];
		flag_set[8][`PIF_MEASURE_TIMER2_OVERFLOW_FLAG_BIT] = measure_timer_overflow[1];
		flag_set[8][`PIF_MEASURE_TIMER1_PERIOD_FLAG_BIT] = measure_timer_period_acq[0];
		flag_set[8][`PIF_MEASURE_TIMER2_PERIOD_FLAG_BIT] = measure_timer_period_acq[1];
		flag_set[8][`PIF_MEASURE_TIMER1_WIDTH_FLAG_BIT] = measure_timer_width_acq[0];
		flag_set[8][`PIF_MEASURE_TIMER2_WIDTH_FLAG_BIT] = measure_timer_width_acq[1];
	end

	// ----------------------------------------------------------------------
	// flag and enable groups
	// ----------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : g_group
			logic flag_wr;
			assign flag_wr = wr_access && flag_dec[4] && flag_dec[3:0] == 4'(g);

			// flags stay set until software writes them back to zero
			pif_flag_group #(
				.IMPL_MASK(FLAG_MASK[g])
			) u_flags (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(flag_wr),
				.wr_data(pwdata[7:0]),
				.hw_set(flag_set[g]),
				.value(flag_q[g])
			);

			// enables share the flag layout bit for bit
			// they reset clear, so no stale flag fires before software opts in
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					enable_q[g] <= `PIF_ENABLE_RESET;
				end else if (wr_access && enable_dec[4] && enable_dec[3:0] == 4'(g)) begin
					enable_q[g] <= pwdata[7:0] & FLAG_MASK[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------------
	// global control
	// ----------------------------------------------------------------------
	// only the two gates and the edge select are stored, the rest reads zero
	pif_byte_t control;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control <= `PIF_CONTROL_RESET;
		end else if (wr_access && paddr == `PIF_CONTROL_ADDR) begin
			control <= pwdata[7:0] & `PIF_CONTROL_MASK;
		end
	end

	assign int_edge_select = control[`PIF_INT_EDGE_SELECT_BIT];

	// ----------------------------------------------------------------------
	// request combining
	// ----------------------------------------------------------------------
	logic pending;
	logic next_cpu_int_request;

	// a stale flag raises a request as soon as its enable is set
	always_comb begin
		pending = 1'b0;
		for (int i = 0; i < GROUPS; i++) begin
			pending = pending | (|(flag_q[i] & enable_q[i]));
		end
		next_cpu_int_request = pending
			&& control[`PIF_GLOBAL_INT_ENABLE_BIT]
			&& control[`PIF_PERIPHERAL_INT_ENABLE_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_int_request <= 1'b0;
		end else begin
			cpu_int_request <= next_cpu_int_request;
		end
	end

	// ----------------------------------------------------------------------
	// block status, mask and interrupt line
	// ----------------------------------------------------------------------
	pif_byte_t irq_status;
	pif_byte_t irq_mask;
	pif_byte_t status_set;
	pif_byte_t status_clr;

	always_comb begin
		status_set = 8'h00;
		status_set[`PIF_IRQ_REQ_RISE_BIT] = next_cpu_int_request && !cpu_int_request;
		status_set[`PIF_IRQ_BUS_ERROR_BIT] = pslverr;
		status_clr = 8'h00;
		if (wr_access && paddr == `PIF_IRQ_STATUS_ADDR) begin
			status_clr = pwdata[7:0];
		end
	end

	// set beats a write-one-to-clear landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= `PIF_IRQ_RESET;
		end else begin
			irq_status <= ((irq_status & ~status_clr) | status_set)
				& `PIF_IRQ_MASK_BITS;
		end
	end

	// the mask gates only the block line, never the cpu request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= `PIF_IRQ_RESET;
		end else if (wr_access && paddr == `PIF_IRQ_MASK_ADDR) begin
			irq_mask <= pwdata[7:0] & `PIF_IRQ_MASK_BITS;
		end
	end

	// registered, so the line is glitch free and one edge behind the status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------------
	// unmapped words read zero as well as raising the error
	pif_byte_t read_byte;

	always_comb begin
		read_byte = 8'h00;
		if (flag_dec[4]) begin
			read_byte = flag_q[flag_dec[3:0]];
		end else if (enable_dec[4]) begin
			read_byte = enable_q[enable_dec[3:0]];
		end else if (paddr == `PIF_CONTROL_ADDR) begin
			read_byte = control;
		end else if (paddr == `PIF_IRQ_STATUS_ADDR) begin
			read_byte = irq_status;
		end else if (paddr == `PIF_IRQ_MASK_ADDR) begin
			read_byte = irq_mask;
		end
	end

	// captured in the setup cycle, so it shows state one cycle before the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata <= {24'h00_0000, read_byte};
		end
	end

endmodule

/* tb/pif_intr_flags_properties.sv */
`timescale 1ns/1ps
`include "pif_defs.svh"

module pif_intr_flags_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// event sources
	input wire pif_pkg::pif_ccp_mode_e ccp1_mode,
	input wire logic [4:0] ccp_capture_event,
	input wire logic scanner_run_bit,
	input wire logic [1:0] measure_timer_overflow,
	// requests
	input wire logic cpu_int_request,
	input wire logic int_edge_select,
	input wire logic irq
);
	import pif_pkg::*;
	logic acc;
	logic rd_setup;
	logic ctl_wr;
	logic bad;
	logic unimpl_ok;
	logic cap_hit;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	assign acc = psel && penable;
	assign rd_setup = psel && !penable && !pwrite;
	assign ctl_wr = acc && pwrite && paddr == `PIF_CONTROL_ADDR;
	assign cap_hit = ccp_capture_event[0] && ccp1_mode == PIF_MODE_CAPTURE;
	// holes between the groups and misaligned words must answer with an error
	assign bad = paddr[1:0] != 2'b00 || paddr > `PIF_IRQ_MASK_ADDR
		|| (paddr > 12'h020 && paddr < 12'h040) || (paddr > 12'h060 && paddr < 12'h080);
	assign unimpl_ok = prdata[31:8] == 24'h00_0000 && (paddr != 12'h018 || prdata[7:5] == 3'h0)
		&& (paddr != 12'h01C || !prdata[3]) && (paddr != 12'h020 || prdata[7:6] == 2'h0);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	reset_clear_a: assert property ($rose(presetn) |-> !cpu_int_request && !irq)
		else $error("requests not clear after reset");
	bus_error_a: assert property (acc |-> pslverr == bad)
		else $error("slave error does not match address");
	unimpl_zero_a: assert property (acc && !pwrite |-> unimpl_ok)
		else $error("unimplemented bits read nonzero");
	capture_set_a: assert property (cap_hit ##[1:3] (rd_setup && paddr == 12'h018) |=> prdata[0])
		else $error("capture did not set unit flag");
	scan_done_a: assert property ($fell(scanner_run_bit) ##[1:3] (rd_setup && paddr == 12'h01C) |=> prdata[7])
		else $error("scanner stop did not set done flag");
	timer_ovf_a: assert property (measure_timer_overflow[1] ##[1:3] (rd_setup && paddr == 12'h020) |=> prdata[3])
		else $error("timer overflow did not set flag");
	global_gate_a: assert property (ctl_wr && pwdata[7:6] != 2'b11 |-> ##2 !cpu_int_request)
		else $error("request passed a closed global gate");
	edge_sel_a: assert property (ctl_wr |=> int_edge_select == $past(pwdata[0]))
		else $error("edge select not written");
	irq_mask_a: assert property (acc && pwrite && paddr == `PIF_IRQ_MASK_ADDR && pwdata[1:0] == 2'b00 |-> ##2 !irq)
		else $error("irq high with mask cleared");
	cover property ($rose(cpu_int_request));
	cover property ($rose(irq));
	cover property (acc && pslverr);
endmodule

bind pif_intr_flags pif_intr_flags_properties u_props (
	.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pslverr,
	.ccp1_mode, .ccp_capture_event, .scanner_run_bit, .measure_timer_overflow,
	.cpu_int_request, .int_edge_select, .irq
);

/* tb/pif_event_source.sv */
`timescale 1ns/1ps

module pif_event_source (
	// clock
	input wire logic pclk,
	// pulse sources, then level sources and unit modes
	output logic [13:0][7:0] ev,
	output logic [7:0][7:0] lv
);
	initial begin
		ev = '0;
		lv = '0;
	end
	// pulses last exactly one cycle, as the peripherals deliver them
	task automatic pulse(input int sel, input logic [7:0] v);
		@(posedge pclk);
		ev[sel] <= v;
		@(posedge pclk);
		ev[sel] <= 8'h00;
	endtask
	task automatic level(input int sel, input logic [7:0] v);
		@(posedge pclk);
		lv[sel] <= v;
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`include "pif_defs.svh"

module tb_top;
	import pif_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cpu_int_request;
	logic int_edge_select;
	logic irq;
	logic [13:0][7:0] ev;
	logic [7:0][7:0] lv;
	logic [31:0] q;
	logic e;
	int err_count = 0;
	int checked = 0;
	logic [7:0] impl [9] = '{`PIF_MASK_G0, `PIF_MASK_G1, `PIF_MASK_G2, `PIF_MASK_G3,
		`PIF_MASK_G4, `PIF_MASK_G5, `PIF_MASK_G6, `PIF_MASK_G7, `PIF_MASK_G8};
	pif_ccp_mode_e md_tab [3] = '{PIF_MODE_CAPTURE, PIF_MODE_COMPARE, PIF_MODE_PWM};

	always #12.5 pclk = ~pclk;

	pif_event_source src (.pclk(pclk), .ev(ev), .lv(lv));

	pif_intr_flags DUT (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_group0(ev[0]), .event_group1(ev[1]), .event_group2(ev[2]),
		.event_group3(ev[3]), .event_group4(ev[4]), .event_group5(ev[5]),
		.ccp1_mode(pif_ccp_mode_e'(lv[3][1:0])), .ccp2_mode(pif_ccp_mode_e'(lv[4][1:0])),
		.ccp3_mode(pif_ccp_mode_e'(lv[5][1:0])), .ccp4_mode(pif_ccp_mode_e'(lv[6][1:0])),
		.ccp5_mode(pif_ccp_mode_e'(lv[7][1:0])), .ccp_capture_event(ev[6][4:0]),
		.ccp_compare_match(ev[7][4:0]), .ccp_pwm_trailing_edge(ev[8][4:0]),
		.scanner_run_bit(lv[0][0]), .checksum_busy(lv[1][0]), .nonvolatile_op_done(ev[9][0]),
		.numeric_osc_rollover(ev[10][0]), .waveform_gen_shutdown(lv[2][2:0]),
		.measure_timer_overflow(ev[11][1:0]), .measure_timer_period_acq(ev[12][1:0]),
		.measure_timer_width_acq(ev[13][1:0]), .cpu_int_request(cpu_int_request),
		.int_edge_select(int_edge_select), .irq(irq)
	);

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, {24'h00_0000, x});
	endtask
	// three edges cover the request latency and the irq stage behind it
	task automatic pc(input logic c, input logic i);
		repeat (3) @(posedge pclk);
		chk({30'h0000_0000, cpu_int_request, irq}, {30'h0000_0000, c, i});
	endtask
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int g = 0; g < 9; g++) begin
			rd(12'(4 * g), 8'h00);
			rd(`PIF_ENABLE_BASE + 12'(4 * g), 8'h00);
			wr(12'(4 * g), 8'hFF);
			rd(12'(4 * g), impl[g]);
			wr(`PIF_ENABLE_BASE + 12'(4 * g), 8'hFF);
			rd(`PIF_ENABLE_BASE + 12'(4 * g), impl[g]);
			wr(12'(4 * g), 8'h00);
			wr(`PIF_ENABLE_BASE + 12'(4 * g), 8'h00);
		end
		for (int g = 0; g < 6; g++) begin
			src.pulse(g, 8'hFF);
			rd(12'(4 * g), impl[g]);
			wr(12'(4 * g), 8'h00);
		end
		for (int m = 0; m < 3; m++) begin
			for (int u = 0; u < 5; u++) src.level(3 + u, 8'(md_tab[m]));
			for (int k = 0; k < 3; k++) begin
				src.pulse(6 + k, 8'h1F);
				rd(12'h018, (k == m) ? 8'h1F : 8'h00);
				wr(12'h018, 8'h00);
			end
		end
		for (int u = 0; u < 5; u++) src.level(3 + u, 8'h00);
		for (int k = 0; k < 3; k++) src.pulse(6 + k, 8'h1F);
		rd(12'h018, 8'h00);
		src.level(0, 8'h01);
		src.level(1, 8'h01);
		rd(12'h01C, 8'h00);
		src.level(0, 8'h00);
		rd(12'h01C, 8'h80);
		src.level(1, 8'h00);
		rd(12'h01C, 8'hC0);
		src.pulse(9, 8'h01);
		src.pulse(10, 8'h01);
		src.level(2, 8'h07);
		rd(12'h01C, 8'hF7);
		src.level(2, 8'h00);
		src.pulse(11, 8'h03);
		rd(12'h020, 8'h09);
		src.pulse(12, 8'h03);
		rd(12'h020, 8'h1B);
		src.pulse(13, 8'h03);
		rd(12'h020, 8'h3F);
		wr(12'h020, 8'h00);
		wr(12'h060, 8'h01);
		wr(`PIF_CONTROL_ADDR, 8'hC0);
		wr(`PIF_IRQ_MASK_ADDR, 8'h01);
		src.pulse(11, 8'h02);
		pc(1'b0, 1'b0);
		src.pulse(11, 8'h01);
		pc(1'b1, 1'b1);
		rd(`PIF_IRQ_STATUS_ADDR, 8'h01);
		wr(`PIF_CONTROL_ADDR, 8'h80);
		pc(1'b0, 1'b1);
		wr(`PIF_CONTROL_ADDR, 8'h40);
		pc(1'b0, 1'b1);
		wr(`PIF_CONTROL_ADDR, 8'hC1);
		pc(1'b1, 1'b1);
		chk({31'h0000_0000, int_edge_select}, 32'h0000_0001);
		wr(`PIF_IRQ_MASK_ADDR, 8'h00);
		pc(1'b1, 1'b0);
		wr(`PIF_IRQ_STATUS_ADDR, 8'h01);
		rd(`PIF_IRQ_STATUS_ADDR, 8'h00);
		wr(12'h020, 8'h00);
		pc(1'b0, 1'b0);
		wr(`PIF_IRQ_MASK_ADDR, 8'h03);
		apb(1'b0, 12'h0C0, 8'h00);
		chk(q, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		pc(1'b0, 1'b1);
		rd(`PIF_IRQ_STATUS_ADDR, 8'h02);
		wr(`PIF_IRQ_STATUS_ADDR, 8'h02);
		pc(1'b0, 1'b0);
		wr(12'h01C, 8'hFF);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h01C, 8'h00);
		rd(`PIF_CONTROL_ADDR, 8'h00);
		wrap_up();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		wrap_up();
	end
endmodule
